// ==== design/dsfp_defines.vh ====
// constants for the processor serial frame port
`ifndef DSFP_DEFINES_VH
`define DSFP_DEFINES_VH
// ----------------------------------------------------------------------
// framing
// ----------------------------------------------------------------------
`define DSFP_SLOT_BITS       16
`define DSFP_TX_SLOTS        52
`define DSFP_RX_SLOTS        84
// serial clock is one quarter of the video clock
`define DSFP_CLK_DIV         4
`define DSFP_WORD_W          16
`define DSFP_SLOT_CNT_W      7
`define DSFP_BIT_CNT_W       4
// divider phases: the edge that raises the serial clock and the one that lowers it
`define DSFP_DIV_RISE        2'h3
`define DSFP_DIV_FALL        2'h1
// index of the last bit of a slot
`define DSFP_LAST_BIT        4'hF
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DSFP_RST_IRQ_N       1'b1
`define DSFP_RST_SYNC        1'b0
`endif

// ==== design/dsfp_sync2.v ====
// two flop synchroniser for pins arriving from the processor
`timescale 1ns/100ps
module dsfp_sync2 #(
  parameter W = 2
) (
  input  wire         clk_i,
  input  wire         reset_n_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  // ----------------------------------------------------------------------
  // first stage feeds only the second stage
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end
  assign q_o = sync_r;
endmodule

// ==== design/dsfp_port.v ====
// processor serial frame port: statistics out, bin widths in, interrupt line
`timescale 1ns/100ps
// Function
// - transmit frame sync pulses high one serial clock before each outgoing frame
// - every frame sync high and low phase lasts at least one serial clock
// - outgoing frame holds 52 slots of 16 bits
// - incoming frame holds 84 slots of 16 bits
// - interrupt held low across statistics send and following bin width receive
// - interrupt assertion marks start of a new statistics packet
// - interrupt falling edge marks a new video field for other logic
// - serial bit clock is one quarter of the video clock
// - words are 16 bits, most significant bit first
// - senders change data after rising edge, receivers sample on falling edge
`include "dsfp_defines.vh"
module dsfp_port #(
  parameter TX_SLOTS = `DSFP_TX_SLOTS,
  parameter RX_SLOTS = `DSFP_RX_SLOTS
) (
  input  wire                    clk_i,
  input  wire                    reset_n_i,
  input  wire                    proc_present_i,
  input  wire                    field_start_i,
  input  wire [`DSFP_WORD_W-1:0] tx_word_i,
  output wire                    tx_word_req_o,
  output wire [`DSFP_WORD_W-1:0] rx_word_o,
  output wire                    rx_word_valid_o,
  output wire                    rx_frame_done_o,
  output wire                    busy_o,
  output wire                    serial_bit_clock_o,
  output wire                    tx_data_o,
  output wire                    tx_frame_sync_o,
  input  wire                    rx_data_i,
  input  wire                    rx_frame_sync_i,
  output wire                    proc_irq_n_o
);
  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 4'h1;
  localparam ST_MARK = 4'h2;
  localparam ST_SEND = 4'h4;
  localparam ST_RECV = 4'h8;
  // last slot indices, cut to the slot counter width on purpose
  localparam [31:0] TX_LAST = TX_SLOTS - 1;
  localparam [31:0] RX_LAST = RX_SLOTS - 1;

  reg [3:0]                    state_r;
  reg [3:0]                    state_nxt;
  reg [1:0]                    div_r;
  reg                          sclk_r;
  reg                          tfs_r;
  reg                          txd_r;
  reg                          irq_n_r;
  reg [`DSFP_WORD_W-1:0]       tx_sh_r;
  reg [`DSFP_BIT_CNT_W-1:0]    tx_bit_r;
  reg [`DSFP_SLOT_CNT_W-1:0]   tx_slot_r;
  reg                          tx_req_r;
  reg [`DSFP_WORD_W-1:0]       rx_sh_r;
  reg [`DSFP_WORD_W-1:0]       rx_word_r;
  reg                          rx_valid_r;
  reg                          rx_done_r;
  reg [`DSFP_BIT_CNT_W-1:0]    rx_bit_r;
  reg [`DSFP_SLOT_CNT_W-1:0]   rx_slot_r;
  reg                          rx_armed_r;
  reg                          rx_in_r;
  reg                          rfs_prev_r;
  wire [1:0]                   pin_sync;
  wire                         rxd_s;
  wire                         rfs_s;
  wire                         rise_tick;
  wire                         fall_tick;
  wire                         last_tx_bit;
  wire                         last_rx_bit;

  // ----------------------------------------------------------------------
  // pin synchronisers for processor driven inputs
  // ----------------------------------------------------------------------
  dsfp_sync2 #(
    .W (2)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({rx_frame_sync_i, rx_data_i}),
    .q_o       (pin_sync)
  );
  assign rxd_s = pin_sync[0];
  assign rfs_s = pin_sync[1];

  // ----------------------------------------------------------------------
  // serial clock divider
  // ----------------------------------------------------------------------
  // divide by four: high for two clocks, low for two; runs free so the
  // processor sees a steady external bit clock
  assign rise_tick = (div_r == `DSFP_DIV_RISE); // next edge drives the serial clock high
  assign fall_tick = (div_r == `DSFP_DIV_FALL); // next edge drives it low
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_r  <= 2'h0;
      sclk_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      if (rise_tick) begin
        sclk_r <= 1'b1;
      end else if (fall_tick) begin
        sclk_r <= 1'b0;
      end
    end
  end

  assign last_tx_bit = (tx_bit_r == `DSFP_LAST_BIT) &&
                       (tx_slot_r == TX_LAST[`DSFP_SLOT_CNT_W-1:0]);
  assign last_rx_bit = (rx_bit_r == `DSFP_LAST_BIT) &&
                       (rx_slot_r == RX_LAST[`DSFP_SLOT_CNT_W-1:0]);

  // ----------------------------------------------------------------------
  // exchange sequencer
  // ----------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // no processor, no exchange: frame sync, data and interrupt pins stay quiet
        if (field_start_i && proc_present_i && rise_tick) begin
          state_nxt = ST_MARK;
        end
      end
      ST_MARK: begin
        if (rise_tick) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (rise_tick && last_tx_bit) begin
          state_nxt = ST_RECV;
        end
      end
      ST_RECV: begin
        if (rise_tick && rx_in_r && last_rx_bit) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // transmit side: updates on the same video clock edge that raises the serial clock
  // so data leaves right after the rise and is steady at the fall
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r   <= ST_IDLE;
      tfs_r     <= `DSFP_RST_SYNC;
      txd_r     <= 1'b0;
      irq_n_r   <= `DSFP_RST_IRQ_N;
      tx_sh_r   <= {`DSFP_WORD_W{1'b0}};
      tx_bit_r  <= 4'h0;
      tx_slot_r <= 7'h00;
      tx_req_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      tx_req_r <= 1'b0;
      if (state_r == ST_IDLE && state_nxt == ST_MARK) begin
        tfs_r     <= 1'b1;
        irq_n_r   <= 1'b0;
        tx_sh_r   <= tx_word_i;
        tx_req_r  <= 1'b1;
        tx_bit_r  <= 4'h0;
        tx_slot_r <= 7'h00;
      end else if (state_r == ST_MARK && rise_tick) begin
        // marker lasted exactly one serial period; low for the whole frame
        tfs_r   <= 1'b0;
        txd_r   <= tx_sh_r[15];
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end else if (state_r == ST_SEND && rise_tick) begin
        if (tx_bit_r == `DSFP_LAST_BIT) begin
          tx_bit_r <= 4'h0;
          if (!last_tx_bit) begin
            tx_slot_r <= tx_slot_r + 7'h01;
            txd_r     <= tx_word_i[15];
            tx_sh_r   <= {tx_word_i[14:0], 1'b0};
            tx_req_r  <= 1'b1;
          end else begin
            txd_r <= 1'b0;
          end
        end else begin
          tx_bit_r <= tx_bit_r + 4'h1;
          txd_r    <= tx_sh_r[15];
          tx_sh_r  <= {tx_sh_r[14:0], 1'b0};
        end
      end else if (state_r == ST_RECV && state_nxt == ST_IDLE) begin
        irq_n_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive side: works on the serial rise, when the synchroniser shows the
  // pins as they stood at the serial fall two video clocks earlier; reading
  // at the fall itself would catch the bit before the processor's change
  // a rising receive frame sync arms the frame, first bit comes one period later
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rfs_prev_r <= 1'b0;
      rx_armed_r <= 1'b0;
      rx_in_r    <= 1'b0;
      rx_sh_r    <= {`DSFP_WORD_W{1'b0}};
      rx_word_r  <= {`DSFP_WORD_W{1'b0}};
      rx_valid_r <= 1'b0;
      rx_done_r  <= 1'b0;
      rx_bit_r   <= 4'h0;
      rx_slot_r  <= 7'h00;
    end else begin
      rx_valid_r <= 1'b0;
      rx_done_r  <= 1'b0;
      if (rise_tick) begin
        rfs_prev_r <= rfs_s;
        if (state_r != ST_RECV) begin
          rx_armed_r <= 1'b0;
          rx_in_r    <= 1'b0;
        end else if (rx_armed_r) begin
          rx_armed_r <= 1'b0;
          rx_in_r    <= 1'b1;
          rx_sh_r    <= {rx_sh_r[14:0], rxd_s};
          rx_bit_r   <= 4'h1;
          rx_slot_r  <= 7'h00;
        end else if (rx_in_r) begin
          rx_sh_r <= {rx_sh_r[14:0], rxd_s};
          if (rx_bit_r == `DSFP_LAST_BIT) begin
            rx_bit_r   <= 4'h0;
            rx_word_r  <= {rx_sh_r[14:0], rxd_s};
            rx_valid_r <= 1'b1;
            rx_slot_r  <= rx_slot_r + 7'h01;
            if (last_rx_bit) begin
              rx_in_r   <= 1'b0;
              rx_done_r <= 1'b1;
            end
          end else begin
            rx_bit_r <= rx_bit_r + 4'h1;
          end
        end else if (rfs_s && !rfs_prev_r) begin
          rx_armed_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign serial_bit_clock_o = sclk_r;
  assign tx_data_o          = txd_r;
  assign tx_frame_sync_o    = tfs_r;
  assign proc_irq_n_o       = irq_n_r;
  assign tx_word_req_o      = tx_req_r;
  assign rx_word_o          = rx_word_r;
  assign rx_word_valid_o    = rx_valid_r;
  assign rx_frame_done_o    = rx_done_r;
  assign busy_o             = (state_r != ST_IDLE);
endmodule

// ==== tb/dsfp_checker.sv ====
// concurrent checks on the pins of the processor serial frame port
`timescale 1ns/100ps
module dsfp_checker #(
  parameter TX_SLOTS = 52,
  parameter RX_SLOTS = 84
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic serial_bit_clock_o,
  input wire logic tx_data_o,
  input wire logic tx_frame_sync_o,
  input wire logic tx_word_req_o,
  input wire logic rx_word_valid_o,
  input wire logic busy_o,
  input wire logic proc_irq_n_o
);
  int req_cnt_r;
  int rx_cnt_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // words moved in this exchange; restart on the marker so an aborted run cannot leak in
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      req_cnt_r <= 0;
      rx_cnt_r  <= 0;
    end else if ($rose(tx_frame_sync_o)) begin
      req_cnt_r <= 1;
      rx_cnt_r  <= 0;
    end else begin
      req_cnt_r <= req_cnt_r + tx_word_req_o;
      rx_cnt_r  <= rx_cnt_r + rx_word_valid_o;
    end
  end
  // two video clocks high, two low
  sequence sclk_cycle_s;
    serial_bit_clock_o [*2] ##1 !serial_bit_clock_o [*2] ##1 serial_bit_clock_o;
  endsequence
  // two video clocks low, then two high
  sequence sclk_low_s;
    !serial_bit_clock_o [*2] ##1 serial_bit_clock_o [*2];
  endsequence
  // marker holds one serial period, frame starts on the next serial rise
  sequence marker_s;
    tx_frame_sync_o [*4] ##1 (!tx_frame_sync_o && $rose(serial_bit_clock_o));
  endsequence
  sclk_fall_a: assert property ($fell(serial_bit_clock_o) |-> sclk_low_s)
    else $error("serial clock not a quarter of the video clock");
  sclk_shape_a: assert property ($rose(serial_bit_clock_o) |-> sclk_cycle_s)
    else $error("serial clock shape wrong");
  sync_pulse_a: assert property ($rose(tx_frame_sync_o) |-> marker_s)
    else $error("transmit marker width or position wrong");
  irq_start_a: assert property ($rose(tx_frame_sync_o) |-> $fell(proc_irq_n_o) && tx_word_req_o)
    else $error("interrupt not asserted with the marker");
  field_mark_a: assert property ($fell(proc_irq_n_o) |-> $rose(tx_frame_sync_o))
    else $error("interrupt asserted without a new exchange");
  irq_release_a: assert property ($rose(proc_irq_n_o) |-> req_cnt_r == TX_SLOTS
    && rx_cnt_r == RX_SLOTS - 1 && rx_word_valid_o) else $error("interrupt released early");
  irq_busy_a: assert property (!proc_irq_n_o |-> busy_o)
    else $error("interrupt low while idle");
  data_edge_a: assert property (busy_o && $past(busy_o) && $changed(tx_data_o)
    |-> $rose(serial_bit_clock_o)) else $error("transmit data moved off a serial rise");
  next_word_a: assert property ($rose(tx_frame_sync_o) |-> ##68 tx_word_req_o)
    else $error("second slot not started sixteen bits after the first");
endmodule
bind dsfp_port dsfp_checker #(.TX_SLOTS(TX_SLOTS), .RX_SLOTS(RX_SLOTS)) dsfp_checker_i (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .serial_bit_clock_o(serial_bit_clock_o),
  .tx_data_o(tx_data_o), .tx_frame_sync_o(tx_frame_sync_o), .tx_word_req_o(tx_word_req_o),
  .rx_word_valid_o(rx_word_valid_o), .busy_o(busy_o), .proc_irq_n_o(proc_irq_n_o));

// ==== tb/dsfp_proc_model.sv ====
// behavioural model of the external processor serial port
`timescale 1ns/100ps
module dsfp_proc_model (
  input  wire logic       reset_n_i,
  input  wire logic       sclk_i,
  input  wire logic       tx_data_i,
  input  wire logic       tx_sync_i,
  input  wire logic       irq_n_i,
  input  wire logic [7:0] gap_i,
  output logic            rx_data_o = 1'b0,
  output logic            rx_sync_o = 1'b0
);
  logic [15:0] cap [0:51];
  logic [15:0] send [0:83];
  logic [15:0] sh;
  int rbits = -1;
  int tbits = -1;
  int wait_n = -1;
  int irq_cnt = 0;
  // interrupt taken on its asserting edge only: the line stays low all exchange
  always @(negedge irq_n_i) irq_cnt++;
  // a reset drops both directions mid frame
  always @(negedge reset_n_i) begin
    rbits = -1;
    tbits = -1;
    wait_n = -1;
    rx_sync_o <= 1'b0;
  end
  // receive side framed only by the device marker, sampled on falls
  always @(negedge sclk_i) begin
    if (tx_sync_i) rbits = 0;
    else if (rbits >= 0 && rbits < 832) begin
      sh = {sh[14:0], tx_data_i};
      rbits++;
      if (rbits % 16 == 0) cap[rbits / 16 - 1] = sh;
      if (rbits == 832) wait_n = gap_i;
    end
  end
  // own framing on send; the line toggles between frames so stale bits never look valid
  always @(posedge sclk_i) begin
    if (wait_n == 0) begin
      rx_sync_o <= 1'b1;
      wait_n = -1;
      tbits = 0;
    end else begin
      if (wait_n > 0) wait_n--;
      rx_sync_o <= 1'b0;
      if (tbits >= 0 && tbits < 1344) begin
        rx_data_o <= send[tbits / 16][15 - tbits % 16];
        tbits++;
      end else rx_data_o <= ~rx_data_o;
    end
  end
endmodule

// ==== tb/dsfp_port_bench.sv ====
// self-checking bench for the processor serial frame port
`timescale 1ns/100ps
module dsfp_port_bench;
  logic clk_i = 1'b0, reset_n_i = 1'b0, proc_present_i = 1'b0, field_start_i = 1'b0;
  logic [15:0] tx_word_i = 16'h0000;
  logic [15:0] rx_word_o;
  logic [7:0] gap = 8'h00;
  logic req, valid, done, busy_o, sclk, txd, txs, rxd, rxs, proc_irq_n_o;
  logic [15:0] txq [0:51];
  logic [15:0] expq [0:83];
  int mismatches = 0, num_checks = 0, n_req = 0, n_rx = 0, seed;
  always #25 clk_i = ~clk_i;
  dsfp_port dsfp_port_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .proc_present_i(proc_present_i),
    .field_start_i(field_start_i), .tx_word_i(tx_word_i), .tx_word_req_o(req),
    .rx_word_o(rx_word_o), .rx_word_valid_o(valid), .rx_frame_done_o(done), .busy_o(busy_o),
    .serial_bit_clock_o(sclk), .tx_data_o(txd), .tx_frame_sync_o(txs), .rx_data_i(rxd),
    .rx_frame_sync_i(rxs), .proc_irq_n_o(proc_irq_n_o));
  dsfp_proc_model dsfp_proc_model_i (.reset_n_i(reset_n_i), .sclk_i(sclk), .tx_data_i(txd),
    .tx_sync_i(txs), .irq_n_i(proc_irq_n_o), .gap_i(gap), .rx_data_o(rxd), .rx_sync_o(rxs));
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic summarize;
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // feed the next statistics word after each request, compare every received word
  always @(posedge clk_i) begin
    if (req === 1'b1) begin
      n_req <= n_req + 1;
      tx_word_i <= txq[(n_req + 1) % 52];
    end
    if (valid === 1'b1) begin
      check(rx_word_o === expq[n_rx] && done === (n_rx == 83), "bin width word");
      n_rx <= n_rx + 1;
    end
  end
  // one full exchange; start is held 40 clocks into busy so a request during busy is refused
  task automatic exchange(input int g);
    int k;
    int irq0;
    for (k = 0; k < 84; k++) expq[k] = 16'($urandom);
    for (k = 0; k < 84; k++) dsfp_proc_model_i.send[k] = expq[k];
    for (k = 0; k < 52; k++) txq[k] = 16'($urandom);
    n_req = 0;
    n_rx = 0;
    irq0 = dsfp_proc_model_i.irq_cnt;
    @(posedge clk_i);
    gap <= 8'(g);
    tx_word_i <= txq[0];
    field_start_i <= 1'b1;
    for (k = 0; k < 8 && busy_o !== 1'b1; k++) @(posedge clk_i);
    check(busy_o === 1'b1 && proc_irq_n_o === 1'b0, "exchange did not start");
    repeat (40) @(posedge clk_i);
    field_start_i <= 1'b0;
    for (k = 0; k < 20000 && n_rx < 84; k++) @(posedge clk_i);
    check(n_req == 52 && proc_irq_n_o === 1'b1, "word counts or interrupt");
    check(dsfp_proc_model_i.irq_cnt == irq0 + 1, "one interrupt edge per field");
    for (k = 0; k < 52; k++) check(dsfp_proc_model_i.cap[k] === txq[k], "statistics word");
  endtask
  // hang guard: the whole run needs about 26600 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
  initial begin
    seed = $urandom(74);
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    field_start_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    check(busy_o === 1'b0 && proc_irq_n_o === 1'b1, "started without processor");
    proc_present_i <= 1'b1;
    exchange(0);
    exchange(9);
    field_start_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    reset_n_i <= 1'b0;
    field_start_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check(busy_o === 1'b0 && proc_irq_n_o === 1'b1 && txs === 1'b0, "reset mid run");
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    exchange($urandom_range(1, 20));
    summarize();
  end
endmodule
